// ==== hdl/viu_top.sv ====
// vectored interrupt unit: request capture, masking, priority, vector fetch, wishbone registers
`timescale 1ns/10ps
`include "viu_defs.svh"
module viu_top (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [3:0] port3_i, // port 3 input lines bit3..bit0
  input wire logic comparator_one_output_i, // comparator one output level
  input wire logic comparator_two_output_i, // comparator two output level
  input wire logic analog_mode_i, // comparators replace bit1/bit2 pins
  input wire logic timer_zero_eoc_i, // timer zero end of count pulse
  input wire logic timer_one_eoc_i, // timer one end of count pulse
  input wire logic halt_i, // core is halted
  input wire logic [15:0] pc_i, // core program counter to save
  input wire logic [7:0] flags_i, // core status flags to save
  input wire logic protect_option_i, // ram protect option programmed
  input wire logic [7:0] ram_adr_i, // register file address of core access
  output logic ram_block_o, // core access to ram must be blocked
  output logic [11:0] vec_adr_o, // program memory byte address of vector fetch
  output logic vec_rd_o, // vector fetch read strobe
  input wire logic [7:0] vec_dat_i, // program memory byte, valid cycle after vec_rd_o
  output logic save_o, // pulse: core pushes pc and flags
  output logic [15:0] saved_pc_o, // pc captured in the save_o cycle after grant
  output logic [7:0] saved_flags_o, // flags captured in the save_o cycle after grant
  output logic pc_load_o, // pulse: pc_o takes the new vector at the end of this cycle
  output logic [15:0] pc_o, // new program counter
  output logic wake_o, // leave halt
  output logic int_o // level interrupt of unit status events
);
  import viu_pkg::*;

  // ----------------------------------------
  // input capture
  // ----------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] prev;
  logic [1:0] cmp1;
  logic [1:0] cmp2;
  logic [1:0] cmp_prev;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prev <= 4'h0;
      cmp1 <= 2'h0;
      cmp2 <= 2'h0;
      cmp_prev <= 2'h0;
    end
    else
    begin
      sync1 <= port3_i;
      sync2 <= sync1;
      prev <= sync2;
      cmp1 <= {comparator_two_output_i, comparator_one_output_i};
      cmp2 <= cmp1;
      cmp_prev <= cmp2;
    end
  end

  // ----------------------------------------
  // edge selection
  // ----------------------------------------
  function automatic logic edge_hit(input logic now, input logic was, input logic [1:0] mode);
    logic fall;
    logic rise;
    fall = was & ~now;
    rise = now & ~was;
    unique case (mode)
      2'b00: edge_hit = fall;
      2'b01: edge_hit = rise;
      2'b10: edge_hit = fall;
      2'b11: edge_hit = fall | rise;
    endcase
  endfunction

  logic [7:0] req;
  logic [7:0] mask;
  logic [7:0] prio;
  logic [1:0] edge_sel;
  logic b1_now;
  logic b1_was;
  logic b2_now;
  logic b2_was;
  logic [1:0] mode_b1;
  logic [1:0] mode_b2;
  logic [5:0] ev;
  always_comb
  begin
    edge_sel = req[`VIU_REQ_EDGE_HI:`VIU_REQ_EDGE_LO];
    b1_now = analog_mode_i ? cmp2[0] : sync2[1];
    b1_was = analog_mode_i ? cmp_prev[0] : prev[1];
    b2_now = analog_mode_i ? cmp2[1] : sync2[2];
    b2_was = analog_mode_i ? cmp_prev[1] : prev[2];
    // bit1 is the first pin, bit2 the second
    mode_b1 = (edge_sel == 2'b11) ? 2'b11 : (edge_sel[1] ? 2'b01 : 2'b00);
    mode_b2 = (edge_sel == 2'b11) ? 2'b11 : (edge_sel[0] ? 2'b01 : 2'b00);
    ev[0] = edge_hit(b2_now, b2_was, mode_b2);
    ev[1] = prev[3] & ~sync2[3];
    ev[2] = edge_hit(b1_now, b1_was, mode_b1);
    ev[3] = prev[0] & ~sync2[0];
    ev[4] = timer_zero_eoc_i;
    ev[5] = timer_one_eoc_i;
  end

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  logic wb_hit;
  logic wr;
  logic [7:0] wbyte;
  logic [5:0] stat;
  logic [5:0] ien;
  logic [5:0] grant_oh;
  logic grant;
  logic [2:0] grant_idx;
  viu_state_t state;
  viu_wb_req_t wbr;
  // bus request carried as one record
  always_comb
  begin
    wbr.cyc = wb_cyc_i;
    wbr.stb = wb_stb_i;
    wbr.we = wb_we_i;
    wbr.sel = wb_sel_i;
    wbr.adr = wb_adr_i;
    wbr.dat = wb_dat_i;
  end
  assign wb_hit = wbr.cyc & wbr.stb & ~wb_ack_o;
  assign wr = wb_hit & wbr.we & wbr.sel[0];
  assign wbyte = wbr.dat[7:0];

  // write strobe of one register address
  function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] want);
    wr_at = w & (a == want);
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_hit & ~wb_we_i)
    begin
      unique case (wb_adr_i)
        `VIU_ADR_REQ: wb_dat_o <= {24'h000000, req};
        `VIU_ADR_MASK: wb_dat_o <= {24'h000000, mask};
        `VIU_ADR_PRIO: wb_dat_o <= {24'h000000, prio};
        `VIU_ADR_STAT: wb_dat_o <= {26'h0000000, stat};
        `VIU_ADR_IEN: wb_dat_o <= {26'h0000000, ien};
        `VIU_ADR_VEC: wb_dat_o <= {16'h0000, pc_o};
        `VIU_ADR_CTRL: wb_dat_o <= {27'h0000000, state};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // request, mask and priority registers
  // ----------------------------------------
  logic [5:0] clr_grant;
  assign clr_grant = (state == VIU_SAVE) ? grant_oh : 6'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      req <= `VIU_REQ_RST;
    else
    begin
      if (wr_at(wr, wbr.adr, `VIU_ADR_REQ))
        req <= {wbyte[7:6], wbyte[5:0] | ev}; // set beats software clear
      else
        req <= {req[7:6], (req[5:0] & ~clr_grant) | ev};
    end
  end

  logic int_disable;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask <= `VIU_MASK_RST;
    else if (wr_at(wr, wbr.adr, `VIU_ADR_MASK))
      // a grant in the same cycle still turns the global enable off
      mask <= {wbyte[`VIU_MASK_GLOBAL] & ~int_disable, wbyte[6:0]};
    else if (int_disable)
      mask[`VIU_MASK_GLOBAL] <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prio <= `VIU_PRIO_RST;
    else if (wr_at(wr, wbr.adr, `VIU_ADR_PRIO))
      prio <= wbyte;
  end

  // ram protect, either read or write
  assign ram_block_o = protect_option_i & mask[`VIU_MASK_PROTECT]
    & (ram_adr_i >= `VIU_RAM_LO) & (ram_adr_i <= `VIU_RAM_HI);

  // ----------------------------------------
  // priority encoder
  // ----------------------------------------
  logic [5:0] pend;
  assign pend = req[5:0] & mask[5:0] & {6{mask[`VIU_MASK_GLOBAL]}};

  // rotating order: priority register low bits choose the source checked first
  function automatic logic [2:0] pick(input logic [5:0] p, input logic [2:0] start);
    logic [2:0] k;
    pick = 3'd7;
    for (int i = `VIU_NSRC - 1; i >= 0; i--)
    begin
      k = 3'((int'(start) + i) % `VIU_NSRC);
      if (p[k])
        pick = k;
    end
  endfunction

  logic [2:0] first;
  assign first = (prio[2:0] < 3'd6) ? prio[2:0] : 3'd0;
  assign grant_idx = pick(pend, first);
  assign grant = (grant_idx != 3'd7);

  // ----------------------------------------
  // interrupt machine cycle
  // ----------------------------------------
  logic [2:0] cur;
  logic [7:0] vec_hi;
  assign grant_oh = 6'(6'h01 << cur);
  assign int_disable = (state == VIU_IDLE) & grant;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= VIU_IDLE;
      cur <= 3'd0;
      vec_hi <= 8'h00;
      saved_pc_o <= 16'h0000;
      saved_flags_o <= 8'h00;
      pc_o <= `VIU_RESET_PC;
    end
    else
    begin
      unique case (state)
        VIU_IDLE:
          if (grant)
          begin
            cur <= grant_idx;
            state <= VIU_SAVE; // halt does not stop the grant
          end
        VIU_SAVE:
        begin
          saved_pc_o <= pc_i;
          saved_flags_o <= flags_i;
          state <= VIU_FETCH_HI;
        end
        VIU_FETCH_HI:
          state <= VIU_FETCH_LO;
        VIU_FETCH_LO:
        begin
          vec_hi <= vec_dat_i;
          state <= VIU_LOAD;
        end
        VIU_LOAD:
        begin
          pc_o <= {vec_hi, vec_dat_i};
          state <= VIU_IDLE;
        end
        default:
          state <= VIU_IDLE;
      endcase
    end
  end

  logic [11:0] vbase;
  assign vbase = {8'h00, cur, 1'b0};
  assign vec_rd_o = (state == VIU_FETCH_HI) | (state == VIU_FETCH_LO);
  assign vec_adr_o = (state == VIU_FETCH_LO) ? (vbase | 12'h001) : vbase;
  assign save_o = (state == VIU_SAVE);
  assign pc_load_o = (state == VIU_LOAD);
  assign wake_o = halt_i & (state == VIU_SAVE);

  // ----------------------------------------
  // unit status interrupt
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat <= 6'h00;
    else if (wr_at(wr, wbr.adr, `VIU_ADR_STAT))
      stat <= (stat & ~wbyte[5:0]) | ev;
    else
      stat <= stat | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ien <= 6'h00;
    else if (wr_at(wr, wbr.adr, `VIU_ADR_IEN))
      ien <= wbyte[5:0];
  end

  assign int_o = |(stat & ien);
endmodule // viu_top

// ==== hdl/viu_defs.svh ====
// offsets, field positions, reset values and sizes of the vectored interrupt unit
`ifndef VIU_DEFS_SVH
`define VIU_DEFS_SVH
`define VIU_ADR_REQ 8'hFA
`define VIU_ADR_MASK 8'hFB
`define VIU_ADR_PRIO 8'hF9
`define VIU_ADR_STAT 8'hF0
`define VIU_ADR_IEN 8'hF1
`define VIU_ADR_VEC 8'hF2
`define VIU_ADR_CTRL 8'hF3
`define VIU_MASK_GLOBAL 7
`define VIU_MASK_PROTECT 6
`define VIU_REQ_EDGE_HI 7
`define VIU_REQ_EDGE_LO 6
`define VIU_RESET_PC 16'h000C
`define VIU_VEC_BYTES 12
`define VIU_NSRC 6
`define VIU_RAM_LO 8'h80
`define VIU_RAM_HI 8'hEF
`define VIU_REQ_RST 8'h00
`define VIU_MASK_RST 8'h00
`define VIU_PRIO_RST 8'h00
`endif

// ==== hdl/viu_pkg.sv ====
// types of the vectored interrupt unit
package viu_pkg;
  typedef enum logic [4:0] {
    VIU_IDLE = 5'b00001,
    VIU_SAVE = 5'b00010,
    VIU_FETCH_HI = 5'b00100,
    VIU_FETCH_LO = 5'b01000,
    VIU_LOAD = 5'b10000
  } viu_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } viu_wb_req_t;
  typedef struct packed {
    logic [5:0] pin_ev;
    logic [1:0] timer_eoc;
  } viu_src_t;
endpackage

// ==== verif/viu_top_asserts.sv ====
// port checker of the vectored interrupt unit
`timescale 1ns/10ps
module viu_top_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // ack
  input wire logic halt_i, // halted
  input wire logic protect_option_i, // option
  input wire logic [7:0] ram_adr_i, // core address
  input wire logic ram_block_o, // blocked
  input wire logic [11:0] vec_adr_o, // fetch address
  input wire logic vec_rd_o, // fetch strobe
  input wire logic [7:0] vec_dat_i, // fetched byte
  input wire logic save_o, // save pulse
  input wire logic pc_load_o, // load pulse
  input wire logic [15:0] pc_o, // new pc
  input wire logic wake_o // wake
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_pc: assert property ($fell(rst_i) |-> pc_o == 16'h000C)
    else $error("pc not at start");
  a_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_grant_seq: assert property (save_o |=> vec_rd_o ##1 vec_rd_o ##1 pc_load_o)
    else $error("bad grant cycle");
  a_vec_pair: assert property (save_o |=> !vec_adr_o[0] && vec_adr_o < 12'hC
    ##1 vec_adr_o == $past(vec_adr_o) + 12'h1) else $error("bad vector pair");
  a_pc_vector: assert property (pc_load_o |=>
    pc_o == {$past(vec_dat_i, 2), $past(vec_dat_i)}) else $error("pc not vector");
  a_int_off: assert property (save_o |=> (!save_o) [*5])
    else $error("grant while disabled");
  a_wake_halt: assert property (save_o || wake_o |-> wake_o == (save_o && halt_i))
    else $error("bad wake");
  a_ram_guard: assert property (ram_block_o |-> protect_option_i && ram_adr_i >= 8'h80
    && ram_adr_i <= 8'hEF) else $error("bad block");
  c_halt_grant: cover property (save_o && halt_i);
  c_block: cover property (ram_block_o);
  c_bus: cover property (wb_ack_o && wb_cyc_i);
endmodule // viu_top_asserts
bind viu_top viu_top_asserts viu_top_asserts_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .halt_i, .protect_option_i, .ram_adr_i, .ram_block_o, .vec_adr_o, .vec_rd_o, .vec_dat_i,
  .save_o, .pc_load_o, .pc_o, .wake_o);

// ==== verif/viu_core_model.sv ====
// core model: vector table bytes, running pc and flags, halt state
`timescale 1ns/10ps
module viu_core_model (
  input wire logic clk_i, // clock
  input wire logic sleep_i, // enter halt
  input wire logic wake_i, // leave halt
  input wire logic vec_rd_i, // fetch strobe
  input wire logic [11:0] vec_adr_i, // fetch address
  output logic [7:0] vec_dat_o, // fetched byte
  output logic halt_o, // halted
  output logic [15:0] pc_o, // running pc
  output logic [7:0] flags_o // flags
);
  initial
  begin
    vec_dat_o = 8'h00;
    halt_o = 1'h0;
    pc_o = 16'h0100;
    flags_o = 8'h5A;
  end
  // byte valid the cycle after its address, a changing pattern otherwise
  always @(posedge clk_i)
  begin
    vec_dat_o <= vec_rd_i ? (vec_adr_i[7:0] * 8'h1D) ^ 8'hA5 : ~vec_dat_o;
    halt_o <= wake_i ? 1'h0 : (sleep_i | halt_o);
    pc_o <= pc_o + 16'h0003;
    flags_o <= flags_o + 8'h01;
  end
endmodule // viu_core_model

// ==== verif/viu_top_test.sv ====
// self-checking bench of the vectored interrupt unit
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module viu_top_test;
  import viu_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, analog_mode_i, protect_option_i;
  logic comparator_one_output_i, comparator_two_output_i, timer_zero_eoc_i, timer_one_eoc_i;
  logic halt_i, ram_block_o, vec_rd_o, save_o, pc_load_o, wake_o, int_o, sleep, eb;
  logic [3:0] wb_sel_i, port3_i;
  logic [7:0] wb_adr_i, flags_i, ram_adr_i, vec_dat_i, saved_flags_o, sflags, q;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic [11:0] vec_adr_o;
  logic [15:0] pc_i, saved_pc_o, pc_o, spc;
  logic pl_d = 1'h0, sv_d = 1'h0, rd_d = 1'h0;
  int mismatches = 0, tests_run = 0, grants = 0, esrc, m, i, ereq;
  viu_top viu_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .port3_i, .comparator_one_output_i,
    .comparator_two_output_i, .analog_mode_i, .timer_zero_eoc_i, .timer_one_eoc_i, .halt_i,
    .pc_i, .flags_i, .protect_option_i, .ram_adr_i, .ram_block_o, .vec_adr_o, .vec_rd_o,
    .vec_dat_i, .save_o, .saved_pc_o, .saved_flags_o, .pc_load_o, .pc_o, .wake_o, .int_o);
  viu_core_model viu_core_model_i (.clk_i, .sleep_i(sleep), .wake_i(wake_o), .vec_rd_i(vec_rd_o),
    .vec_adr_i(vec_adr_o), .vec_dat_o(vec_dat_i), .halt_o(halt_i), .pc_o(pc_i), .flags_o(flags_i));
  // ---------------
  // model and tasks
  // ---------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] vecw(int n);
    return {(8'(2 * n) * 8'h1D) ^ 8'hA5, (8'(2 * n + 1) * 8'h1D) ^ 8'hA5};
  endfunction
  function int pick(int r, int p);
    int s;
    s = (p >= 6) ? 0 : p;
    for (int k = 0; k < 6; k++)
      if (r[(s + k) % 6]) return (s + k) % 6;
    return -1;
  endfunction
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) @(posedge clk_i);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    `CHK(q, e)
  endtask
  task summarize;
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // grant monitor: fetch address, loaded pc, saved context, wake
  always @(posedge clk_i)
  begin
    if (pl_d) `CHK(pc_o, vecw(esrc))
    if (pl_d) grants++;
    if (sv_d) `CHK({saved_pc_o, saved_flags_o}, {spc, sflags})
    if (vec_rd_o && !rd_d) `CHK(vec_adr_o, 12'(2 * esrc))
    if (save_o) `CHK(wake_o, halt_i)
    spc = pc_i;
    sflags = flags_i;
    pl_d = pc_load_o;
    sv_d = save_o;
    rd_d = vec_rd_o;
  end
  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    #500000;
    mismatches++;
    summarize;
  end
  // -----
  // tests
  // -----
  initial
  begin
    seed = 32'hA140B114;
    {rst_i, comparator_one_output_i, comparator_two_output_i} = 3'h7;
    {wb_cyc_i, wb_stb_i, wb_we_i, analog_mode_i, protect_option_i, sleep} = 6'h0;
    {timer_zero_eoc_i, timer_one_eoc_i, wb_adr_i, wb_dat_i, ram_adr_i} = 50'h0;
    wb_sel_i = 4'h1;
    port3_i = 4'hF;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    `CHK(pc_o, 16'h000C)
    rd(8'hFB, 8'h00);
    rd(8'h10, 8'h00);
    timer_zero_eoc_i <= 1'h1;
    @(posedge clk_i);
    timer_zero_eoc_i <= 1'h0;
    timer_one_eoc_i <= 1'h1;
    @(posedge clk_i);
    timer_one_eoc_i <= 1'h0;
    rd(8'hFA, 8'h30);
    for (m = 0; m < 4; m++)
    begin
      bus(1'h1, 8'hFA, 8'(m << 6));
      port3_i <= 4'h0;
      repeat (4) @(posedge clk_i);
      rd(8'hFA, {2'(m), 3'h1, 1'(m != 2), 1'h1, 1'(m != 1)});
      bus(1'h1, 8'hFA, 8'(m << 6));
      port3_i <= 4'hF;
      repeat (4) @(posedge clk_i);
      rd(8'hFA, {2'(m), 3'h0, 1'(m[1]), 1'h0, 1'(m[0])});
    end
    bus(1'h1, 8'hFA, 8'h00);
    analog_mode_i <= 1'h1;
    comparator_one_output_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    rd(8'hFA, 8'h04);
    comparator_two_output_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    rd(8'hFA, 8'h05);
    bus(1'h1, 8'hFA, 8'h3F);
    bus(1'h1, 8'hFB, 8'h3F);
    bus(1'h1, 8'hFB, 8'h80);
    rd(8'hFA, 8'h3F);
    `CHK(grants, 0)
    for (i = 0; i < 8; i++)
    begin
      ereq = int'(rnd() % 32'h3F) + 1;
      m = int'(rnd() % 32'h8);
      esrc = pick(ereq, m);
      sleep <= i[0];
      bus(1'h1, 8'hF9, 8'(m));
      bus(1'h1, 8'hFA, 8'(ereq));
      bus(1'h1, 8'hFB, 8'hBF);
      for (int w = 0; w < 20 && grants == i; w++) @(posedge clk_i);
      `CHK(grants, i + 1)
      rd(8'hFB, 8'h3F);
      rd(8'hFA, 8'(ereq & ~(1 << esrc)));
      rd(8'hF9, 8'(m));
      rd(8'hF2, 8'(vecw(esrc)));
    end
    rd(8'hF3, 8'h01);
    bus(1'h1, 8'hF1, 8'hFF);
    rd(8'hF0, 8'h3F);
    `CHK(int_o, 1'h1)
    bus(1'h1, 8'hF0, 8'hFF);
    `CHK(int_o, 1'h0)
    rd(8'hF0, 8'h00);
    bus(1'h1, 8'hF1, 8'h00);
    for (i = 0; i < 32; i++)
    begin
      if (i % 16 == 0) bus(1'h1, 8'hFB, (i < 16) ? 8'h40 : 8'h00);
      ram_adr_i <= 8'(rnd());
      protect_option_i <= i[2];
      @(posedge clk_i);
      eb = i < 16 && protect_option_i && ram_adr_i >= 8'h80 && ram_adr_i <= 8'hEF;
      `CHK(ram_block_o, eb)
    end
    summarize;
  end
endmodule // viu_top_test
